// ### src/irq_pin_pkg.sv
// package: register map, field positions, reset values for the external interrupt pin block
package irq_pin_pkg;
  // byte offsets of the words on the register bus
  localparam logic [3:0] ctrl_status_off = 4'h0;
  localparam logic [3:0] int_status_off  = 4'h4;
  localparam logic [3:0] int_mask_off    = 4'h8;
  // bit positions in the control/status byte
  localparam int mode_bit   = 0;
  localparam int ie_bit     = 1;
  localparam int ack_bit    = 2;
  localparam int flag_bit   = 3;
  localparam int pe_bit     = 4;
  localparam int edg_bit    = 5;
  localparam int pdd_bit    = 6;
  localparam int unused_bit = 7;
  // reset values
  localparam logic [7:0] ctrl_reset = 8'h00;
  localparam logic       mask_reset = 1'b0;
  // axi response codes
  localparam logic [1:0] resp_okay   = 2'b00;
  localparam logic [1:0] resp_slverr = 2'b10;
  // synchroniser depth
  localparam int sync_stages = 2;
endpackage

// ### src/pin_sync_if.sv
// interface: synchronised pin level and its edge pulses between the synchroniser and the top
`timescale 1ns/1ps
`default_nettype none
interface pin_sync_if;
  logic level;
  logic rise;
  logic fall;
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface
`default_nettype wire

// ### src/pin_sync.sv
// pin synchroniser: two flops, then a third for edge detection
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
  input  wire logic clock,
  input  wire logic sys_rst,
  input  wire logic pin_in,
  pin_sync_if.src   sync
);
  import irq_pin_pkg::*;

  logic meta_r;
  logic stable_r;
  logic prev_r;

  // meta_r is read only by stable_r
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      meta_r   <= 1'b0;
      stable_r <= 1'b0;
      prev_r   <= 1'b0;
    end else begin
      meta_r   <= pin_in;
      stable_r <= meta_r;
      prev_r   <= stable_r;
    end
  end

  // one pulse per synchronised transition
  assign sync.level = stable_r;
  assign sync.rise  = stable_r & ~prev_r;
  assign sync.fall  = ~stable_r & prev_r;

  a_single_rise : assert property (@(posedge clock) disable iff (sys_rst)
    sync.rise |=> !sync.rise) else $error("rise pulse longer than one cycle");
endmodule
`default_nettype wire

// ### src/ext_irq_pin.sv
// top: external interrupt request pin with control/status register over AXI4-Lite
//
// Overview of operation
// - pull disable bit turns internal pull off while pin function enabled
// - polarity bit: 0 falling edge/low level, 1 rising edge/high level
// - enabled pin gets pull-down for rising, pull-up for falling, unless disabled
// - pin enable 0 disables pin function; no request events detected
// - request flag set by qualifying event, read-only to software
// - writing 1 to acknowledge clears flag; 0 no effect; reads as 0
// - level mode: acknowledge cannot clear flag while pin stays asserted
// - interrupt enable 1 raises request to core whenever flag is 1
// - mode bit 0 edges only, 1 edges and sustained levels
`timescale 1ns/1ps
`default_nettype none
module ext_irq_pin (
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        irq_pin_in,
  output logic             pull_up_en,
  output logic             pull_down_en,
  output logic             core_irq_req,
  output logic             irq,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  import irq_pin_pkg::*;

  // ==========================================================
  // pin synchroniser
  pin_sync_if sync ();

  pin_sync u_sync (
    .clock   (clock),
    .sys_rst (sys_rst),
    .pin_in  (irq_pin_in),
    .sync    (sync)
  );

  // ==========================================================
  // control bits
  logic       pdd_r;
  logic       edg_r;
  logic       pe_r;
  logic       ie_r;
  logic       mode_r;
  logic       flag_r;
  logic       flag_nxt;
  logic       sticky_r;
  logic       mask_r;

  // ==========================================================
  // axi write channel
  logic       aw_held_r;
  logic       w_held_r;
  logic [3:0] awaddr_r;
  logic [7:0] wbyte_r;
  logic       wstrb0_r;
  logic       bvalid_r;
  logic [1:0] bresp_r;
  logic       wr_go;

  assign s_axi_awready = ~aw_held_r & ~bvalid_r;
  assign s_axi_wready  = ~w_held_r & ~bvalid_r;
  assign wr_go         = aw_held_r & w_held_r & ~bvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      aw_held_r <= 1'b0;
      awaddr_r  <= 4'h0;
    end else if (s_axi_awvalid & s_axi_awready) begin
      aw_held_r <= 1'b1;
      awaddr_r  <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_held_r <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      w_held_r <= 1'b0;
      wbyte_r  <= 8'h00;
      wstrb0_r <= 1'b0;
    end else if (s_axi_wvalid & s_axi_wready) begin
      w_held_r <= 1'b1;
      wbyte_r  <= s_axi_wdata[7:0];
      wstrb0_r <= s_axi_wstrb[0];
    end else if (wr_go) begin
      w_held_r <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      bvalid_r <= 1'b0;
      bresp_r  <= resp_okay;
    end else if (wr_go) begin
      bvalid_r <= 1'b1;
      bresp_r  <= (awaddr_r == ctrl_status_off || awaddr_r == int_status_off ||
                   awaddr_r == int_mask_off) ? resp_okay : resp_slverr;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  logic wr_ctrl;
  logic wr_stat;
  logic wr_mask;
  assign wr_ctrl = wr_go & wstrb0_r & (awaddr_r == ctrl_status_off);
  assign wr_stat = wr_go & wstrb0_r & (awaddr_r == int_status_off);
  assign wr_mask = wr_go & wstrb0_r & (awaddr_r == int_mask_off);

  // ==========================================================
  // control register; top bit has no storage
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pdd_r  <= ctrl_reset[pdd_bit];
      edg_r  <= ctrl_reset[edg_bit];
      pe_r   <= ctrl_reset[pe_bit];
      ie_r   <= ctrl_reset[ie_bit];
      mode_r <= ctrl_reset[mode_bit];
    end else if (wr_ctrl) begin
      pdd_r  <= wbyte_r[pdd_bit];
      edg_r  <= wbyte_r[edg_bit];
      pe_r   <= wbyte_r[pe_bit];
      ie_r   <= wbyte_r[ie_bit];
      mode_r <= wbyte_r[mode_bit];
    end
  end

  // ==========================================================
  // detection
  logic edge_hit;
  logic asserted_lvl;
  logic event_hit;
  logic ack_wr;

  assign edge_hit     = edg_r ? sync.rise : sync.fall;
  assign asserted_lvl = edg_r ? sync.level : ~sync.level;
  // level mode holds the set term high while the pin stays asserted
  assign event_hit    = pe_r & (edge_hit | (mode_r & asserted_lvl));
  assign ack_wr       = wr_ctrl & wbyte_r[ack_bit];

  // set beats acknowledge; level mode keeps it set while asserted
  always_comb begin
    flag_nxt = flag_r;
    if (ack_wr) begin
      flag_nxt = 1'b0;
    end
    if (event_hit) begin
      flag_nxt = 1'b1;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      flag_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  // ==========================================================
  // pull control and core request
  assign pull_down_en = pe_r & ~pdd_r & edg_r;
  assign pull_up_en   = pe_r & ~pdd_r & ~edg_r;
  assign core_irq_req = ie_r & flag_r;

  // ==========================================================
  // system interrupt: sticky on flag rising, write one to clear
  logic flag_d_r;
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      flag_d_r <= 1'b0;
      sticky_r <= 1'b0;
      mask_r   <= mask_reset;
    end else begin
      flag_d_r <= flag_r;
      if (flag_r & ~flag_d_r) begin
        sticky_r <= 1'b1;
      end else if (wr_stat & wbyte_r[0]) begin
        sticky_r <= 1'b0;
      end
      if (wr_mask) begin
        mask_r <= wbyte_r[0];
      end
    end
  end
  assign irq = sticky_r & mask_r;

  // ==========================================================
  // axi read channel
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;
  logic [7:0]  ctrl_view;

  assign ctrl_view = {1'b0, pdd_r, edg_r, pe_r, flag_r, 1'b0, ie_r, mode_r};
  assign s_axi_arready = ~rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= resp_okay;
    end else if (s_axi_arvalid & s_axi_arready) begin
      rvalid_r <= 1'b1;
      rresp_r  <= resp_okay;
      unique case (s_axi_araddr)
        ctrl_status_off: rdata_r <= {24'h00_0000, ctrl_view};
        int_status_off:  rdata_r <= {24'h00_0000, 7'h00, sticky_r};
        int_mask_off:    rdata_r <= {24'h00_0000, 7'h00, mask_r};
        default: begin
          rdata_r <= 32'h0000_0000;
          rresp_r <= resp_slverr;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // ==========================================================
  // checks
  sequence s_ack_write;
    wr_ctrl && wbyte_r[ack_bit];
  endsequence

  sequence s_flag_rise;
    !flag_r ##1 flag_r;
  endsequence

  sequence s_read_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  // answers must follow each accepted transfer and hold still while the master stalls
  a_write_answer : assert property (@(posedge clock) disable iff (sys_rst)
    wr_go |=> s_axi_bvalid) else $error("write response missing");
  a_bresp_holds : assert property (@(posedge clock) disable iff (sys_rst)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_read_answer : assert property (@(posedge clock) disable iff (sys_rst)
    s_read_taken |=> s_axi_rvalid) else $error("read data missing");
  a_rdata_holds : assert property (@(posedge clock) disable iff (sys_rst)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");

  // control, flag, pull and edge pulse checks
  a_pull_off : assert property (@(posedge clock) disable iff (sys_rst)
    pdd_r |-> !pull_up_en && !pull_down_en) else $error("pull on while disabled");
  a_pull_dir : assert property (@(posedge clock) disable iff (sys_rst)
    pe_r && !pdd_r |-> (pull_down_en == edg_r) && (pull_up_en == !edg_r))
    else $error("pull direction wrong");
  a_pin_off : assert property (@(posedge clock) disable iff (sys_rst)
    !pe_r && !flag_r |=> !flag_r) else $error("flag set with pin disabled");
  a_edge_sets : assert property (@(posedge clock) disable iff (sys_rst)
    pe_r && (edg_r ? sync.rise : sync.fall) |=> flag_r) else $error("edge missed");
  a_flag_cause : assert property (@(posedge clock) disable iff (sys_rst)
    s_flag_rise |-> $past(event_hit)) else $error("flag set without event");
  a_flag_readonly : assert property (@(posedge clock) disable iff (sys_rst)
    wr_ctrl && wbyte_r[flag_bit] && !flag_r && !event_hit |=> !flag_r) else $error("flag written by software");
  a_ack_clears : assert property (@(posedge clock) disable iff (sys_rst)
    s_ack_write ##0 !event_hit |=> !flag_r) else $error("acknowledge failed");
  a_ack_zero_keeps : assert property (@(posedge clock) disable iff (sys_rst)
    wr_ctrl && !wbyte_r[ack_bit] && flag_r |=> flag_r) else $error("flag cleared without acknowledge");
  a_level_holds : assert property (@(posedge clock) disable iff (sys_rst)
    s_ack_write ##0 pe_r && mode_r && asserted_lvl |=> flag_r) else $error("level flag cleared");
  a_core_req : assert property (@(posedge clock) disable iff (sys_rst)
    core_irq_req == (ie_r && flag_r)) else $error("core request mismatch");
  a_edge_only : assert property (@(posedge clock) disable iff (sys_rst)
    !mode_r && !flag_r && !edge_hit |=> !flag_r) else $error("level set in edge mode");
  a_read_zero : assert property (@(posedge clock) disable iff (sys_rst)
    s_axi_arvalid && s_axi_arready && s_axi_araddr == ctrl_status_off |=>
    !s_axi_rdata[ack_bit] && !s_axi_rdata[unused_bit]) else $error("ack or top bit read one");
  a_one_set : assert property (@(posedge clock) disable iff (sys_rst)
    sync.rise |=> !sync.rise) else $error("double edge pulse");

  // status and interrupt output checks
  a_sticky_set : assert property (@(posedge clock) disable iff (sys_rst)
    s_flag_rise |=> sticky_r) else $error("status not set on flag rise");
  a_irq_masked : assert property (@(posedge clock) disable iff (sys_rst)
    !mask_r |-> !irq) else $error("interrupt raised while masked");
endmodule
`default_nettype wire

// ### dv/pin_drive_model.sv
// partner model: external device on the interrupt pin, seen together with the block's pull devices
`timescale 1ns/1ps
`default_nettype none
module pin_drive_model (
  input  wire logic clock,
  input  wire logic drv_en,
  input  wire logic drv_val,
  input  wire logic pull_up_en,
  input  wire logic pull_down_en,
  output logic      pin
);
  logic last_r = 1'b0;
  // ==========================================
  // pin level
  always_ff @(posedge clock) begin
    last_r <= pin;
  end
  // released and unpulled: keep changing so a stale level never passes for a real one
  always_comb begin
    if (drv_en) pin = drv_val;
    else if (pull_up_en) pin = 1'b1;
    else if (pull_down_en) pin = 1'b0;
    else pin = ~last_r;
  end
endmodule
`default_nettype wire

// ### dv/ext_irq_pin_test.sv
// testbench: external interrupt pin block driven over its register bus and its pin
`timescale 1ns/1ps
`default_nettype none
module ext_irq_pin_test;
  import irq_pin_pkg::*;
  logic        clock = 1'b0, sys_rst = 1'b1, pin, pull_up_en, pull_down_en, core_irq_req, irq;
  logic        drv_en = 1'b0, drv_val = 1'b0;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, d;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [7:0]  v, p;
  int          miscompares = 0, check_count = 0;
  always #10 clock = ~clock;
  ext_irq_pin ext_irq_pin_inst (.clock, .sys_rst, .irq_pin_in(pin), .pull_up_en, .pull_down_en, .core_irq_req,
    .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  pin_drive_model pin_drive_model_inst (.clock, .drv_en, .drv_val, .pull_up_en, .pull_down_en, .pin);
  // ==========================================
  // checking and verdict
  task automatic tally_and_finish();
    $display("checks=%0d miscompares=%0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      miscompares++;
    end
  endtask
  task automatic tmo();
    miscompares++;
    tally_and_finish();
  endtask
  function automatic logic [7:0] exp_ctrl(input logic [7:0] w, input logic f);
    return (w & 8'h73) | {4'h0, f, 3'h0};
  endfunction
  function automatic logic [1:0] exp_pull(input logic [7:0] w);
    return {w[pe_bit] & ~w[pdd_bit] & ~w[edg_bit], w[pe_bit] & ~w[pdd_bit] & w[edg_bit]};
  endfunction
  // ==========================================
  // register bus master
  task automatic wr(input logic [3:0] a, input logic [7:0] x, output logic [1:0] rs);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, x};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int n = 0; n <= 50; n++) begin
      if (n == 50) tmo();
      @(posedge clock);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] x, output logic [1:0] rs);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int n = 0; n <= 50; n++) begin
      if (n == 50) tmo();
      @(posedge clock);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        x = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic cw(input logic [7:0] x);
    wr(ctrl_status_off, x, r);
    chk(32'(r), 32'(resp_okay));
  endtask
  task automatic rc(input logic [7:0] e);
    rd(ctrl_status_off, d, r);
    chk(d, {24'h00_0000, e});
  endtask
  // ==========================================
  // main sequence
  initial begin
    void'($urandom(32'h588e_e371));
    repeat (6) @(posedge clock);
    sys_rst <= 1'b0;
    rc(ctrl_reset);
    rd(int_mask_off, d, r);
    chk(d, 32'(mask_reset));
    // pin function off: random control bytes, pin left random or floating
    repeat (8) begin
      v = 8'($urandom) & 8'hEF;
      drv_en <= 1'($urandom);
      drv_val <= 1'($urandom);
      cw(v);
      rc(exp_ctrl(v, 1'b0));
      chk(32'({pull_up_en, pull_down_en}), 32'h0000_0000);
    end
    for (int i = 0; i < 4; i++) begin
      v = 8'h10 | {1'b0, i[0], i[1], 5'h00};
      cw(v);
      chk(32'({pull_up_en, pull_down_en}), 32'(exp_pull(v)));
    end
    drv_en <= 1'b1;
    for (int e = 0; e < 2; e++) begin
      p = e[0] ? 8'h20 : 8'h00;
      drv_val <= ~e[0];
      cw(8'h10 | p);
      repeat (5) @(posedge clock);
      cw(8'h14 | p);
      cw(8'h12 | p);
      drv_val <= e[0];
      repeat (5) @(posedge clock);
      rc(exp_ctrl(8'h12 | p, 1'b1));
      chk(32'(core_irq_req), 32'h0000_0001);
      cw(8'h16 | p);
      repeat (5) @(posedge clock);
      rc(exp_ctrl(8'h12 | p, 1'b0));
      chk(32'(core_irq_req), 32'h0000_0000);
      drv_val <= ~e[0];
      repeat (5) @(posedge clock);
      rc(exp_ctrl(8'h12 | p, 1'b0));
      cw(8'h11 | p);
      drv_val <= e[0];
      repeat (5) @(posedge clock);
      rc(exp_ctrl(8'h11 | p, 1'b1));
      chk(32'(core_irq_req), 32'h0000_0000);
      cw(8'h15 | p);
      rc(exp_ctrl(8'h11 | p, 1'b1));
      drv_val <= ~e[0];
      repeat (5) @(posedge clock);
      cw(8'h15 | p);
      rc(exp_ctrl(8'h11 | p, 1'b0));
    end
    // sticky status, mask and level output
    rd(int_status_off, d, r);
    chk(d, 32'h0000_0001);
    chk(32'(irq), 32'h0000_0000);
    wr(int_mask_off, 8'h01, r);
    chk(32'(irq), 32'h0000_0001);
    wr(int_status_off, 8'h01, r);
    rd(int_status_off, d, r);
    chk(d, 32'h0000_0000);
    chk(32'(irq), 32'h0000_0000);
    wr(4'hC, 8'hFF, r);
    chk(32'(r), 32'(resp_slverr));
    rd(4'hC, d, r);
    chk(d, 32'h0000_0000);
    chk(32'(r), 32'(resp_slverr));
    // byte lane 0 off: accepted with okay, control byte untouched
    cw(8'h52);
    s_axi_wstrb <= 4'h0;
    wr(ctrl_status_off, 8'h11, r);
    chk(32'(r), 32'(resp_okay));
    s_axi_wstrb <= 4'hF;
    rc(exp_ctrl(8'h52, 1'b0));
    // falling edge with mask on, then a reset in mid-run
    wr(int_mask_off, 8'h01, r);
    drv_val <= 1'b1;
    repeat (5) @(posedge clock);
    drv_val <= 1'b0;
    repeat (5) @(posedge clock);
    chk(32'({core_irq_req, irq}), 32'h0000_0003);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    rc(ctrl_reset);
    rd(int_status_off, d, r);
    chk(d, 32'h0000_0000);
    chk(32'({pull_up_en, pull_down_en, core_irq_req, irq}), 32'h0000_0000);
    tally_and_finish();
  end
endmodule
`default_nettype wire
